// ==== bench/bdc_host_model.sv ====
// serial host model that drives the register port
`timescale 1ns/1ps
module bdc_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl_line,
   output logic      sda_low
);
   initial begin
      scl_line = 1'b1;
      sda_low  = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wt
   // data moves only while the serial clock is low
   task automatic bit_io(input logic b, output logic r);
      wt(5);
      sda_low = ~b;
      wt(15);
      scl_line = 1'b1;
      wt(20);
      r = sda_line;
      scl_line = 1'b0;
   endtask : bit_io
   task automatic start;
      sda_low = 1'b1;
      wt(20);
      scl_line = 1'b0;
   endtask : start
   task automatic stop;
      wt(5);
      sda_low = 1'b1;
      wt(15);
      scl_line = 1'b1;
      wt(20);
      sda_low = 1'b0;
      wt(20);
   endtask : stop
   // ninth bit: m is sent, a is the level seen
   task automatic byte_io(input logic [7:0] w, input logic m,
                          output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], r[i]);
      end
      bit_io(m, a);
   endtask : byte_io
endmodule : bdc_host_model

// ==== bench/tb.sv ====
// self-checking bench of the backlight dimming control
`timescale 1ns/1ps
module tb;
   import bdc_pkg::*;
   localparam logic [6:0] SLV = {I2C_ADDR_BASE[6:1], 1'b1};
   localparam int STEP = int'(STEP_CYCLES[3]);
   logic       sys_clk  = 1'b0;
   logic       lamp_clk = 1'b0;
   logic       resetn;
   logic       por_n;
   logic       dim_osc;
   logic       dim_in;
   logic [6:0] brightness_voltage_in;
   logic [7:0] lsh;
   logic [15:0] ex;
   logic       scl, m_low, sda_line, wave;
   logic [4:0] lcc;
   logic [6:0] pct;
   bdc_pin_t   sda, dsync, lamp_sync_io;
   bdc_gate_t  gate;
   int         miscompares = 0, samples_checked = 0;
   int         ovl = 0, pulses = 0, hi, so;
   string      nq[$];
   logic [15:0] eq[$], obs;
   event       obs_e;
   logic [7:0] code[5] = '{8'h01, 8'h40, 8'h7F, 8'h00, 8'h40};
   logic [7:0] cfg[5]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
   int         win[5]  = '{127, 127, 127, 127, 100};
   logic [7:0] ub[2];
   // pull-up on the shared data line
   assign sda_line = ~(m_low | sda.oe);
   always #50 sys_clk = ~sys_clk;
   initial begin
      #37;
      forever #80 lamp_clk = ~lamp_clk;
   end
   always #250000 dim_osc = ~dim_osc;
   always @(posedge lamp_clk) begin
      ovl += (gate.ch1_a & gate.ch2_a) | (gate.ch1_b & gate.ch2_b);
      pulses += gate.ch1_a | gate.ch2_a;
      lsh = {lsh[6:0], lamp_sync_io.out};
   end
   bdc_host_model h (.sys_clk(sys_clk), .sda_line(sda_line),
                     .scl_line(scl), .sda_low(m_low));
   bdc_top dut (.sys_clk(sys_clk), .resetn(resetn), .por_n(por_n),
      .lamp_clk(lamp_clk), .scl_in(scl), .sda_in(sda_line), .sda(sda),
      .i2c_addr_pin(1'b1), .dimming_osc_pin(dim_osc),
      .dimming_sync_in(dim_in), .dimming_sync(dsync),
      .brightness_level(brightness_voltage_in), .lamp_sync(lamp_sync_io), .gate(gate),
      .burst_dimming_wave(wave), .lamp_current_code(lcc),
      .lamp_current_pct(pct));
   task automatic check(input string n, input logic [15:0] g,
                        input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic note(input string n, input logic [15:0] v);
      nq.push_back(n);
      eq.push_back(v);
   endtask : note
   task automatic seen(input logic [15:0] v);
      obs = v;
      ->obs_e;
      #1;
   endtask : seen
   always @(obs_e) check(nq.pop_front(), obs, eq.pop_front());
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k;
      h.start;
      h.byte_io({SLV, 1'b0}, 1'b1, r, k);
      h.byte_io(a, 1'b1, r, k);
      h.byte_io(d, 1'b1, r, k);
      h.stop;
      h.wt(80);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic [7:0] r;
      logic k;
      h.start;
      h.byte_io({SLV, 1'b0}, 1'b1, r, k);
      h.byte_io(a, 1'b1, r, k);
      h.stop;
      h.start;
      h.byte_io({SLV, 1'b1}, 1'b1, r, k);
      h.byte_io(8'hFF, 1'b1, r, k);
      h.stop;
      seen({8'h00, r});
   endtask : rd
   task automatic rst;
      resetn = 1'b0;
      h.wt(4);
      resetn = 1'b1;
      por_n = 1'b1;
      h.wt(6);
   endtask : rst
   task automatic results;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial begin
      #9_000_000;
      miscompares++;
      results();
   end
   initial begin
      void'($urandom(92986));
      por_n   = 1'b0;
      dim_osc = 1'b0;
      dim_in  = 1'b0;
      brightness_voltage_in  = 7'h00;
      rst();
      note("pct", 16'd100);
      seen(16'(pct));
      note("lamp_sync_io_oe", 16'h0001);
      seen(16'(lamp_sync_io.oe));
      note("bcsc", 16'h0000);
      rd(8'(REG_BCSC));
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         ub[i] = 8'($urandom);
         wr(8'(i * 7), ub[i]);
      end
      for (int i = 0; i < 2; i++) begin
         note("user", {8'h00, ub[i]});
         rd(8'(i * 7));
      end
      note("unmapped", 16'h0000);
      rd(8'h0C);
      $display("test user storage done");
      foreach (ub[i]) begin
         // second pass takes the largest code, the 35 percent end point
         ub[i] = i ? 8'h1F : 8'($urandom_range(31, 1));
         wr(8'(REG_BCSC), ub[i]);
         note("lcc", 16'(ub[i]));
         seen(16'(lcc));
         note("pct", 16'(PCT_FULL - (PCT_SPAN * ub[i]) / 31));
         seen(16'(pct));
      end
      wr(8'(REG_BCSC), 8'h85);
      wr(8'(REG_BCSC), 8'h9A);
      note("bcsc", 16'h009A);
      rd(8'(REG_BCSC));
      rst();
      note("bcsc", 16'h0005);
      rd(8'(REG_BCSC));
      $display("test shadow done");
      brightness_voltage_in = 7'($urandom_range(127, 1));
      wr(8'(REG_CONTROL_ONE), 8'h01);
      dim_in = 1'b1;
      h.wt(10);
      note("wave", 16'h0001);
      seen(16'(wave));
      note("dsync_oe", 16'h0000);
      seen(16'(dsync.oe));
      pulses = 0;
      h.wt(40);
      note("gates_on", 16'h0001);
      seen(16'(pulses != 0));
      dim_in = 1'b0;
      h.wt(10);
      pulses = 0;
      h.wt(400);
      note("gates", 16'h0000);
      seen(16'(pulses));
      wr(8'(REG_CONTROL_ONE), 8'h0C);
      note("lamp_sync_io_oe", 16'h0000);
      seen(16'(lamp_sync_io.oe));
      wr(8'(REG_CONTROL_ONE), 8'h00);
      note("dsync_oe", 16'h0001);
      seen(16'(dsync.oe));
      $display("test sources done");
      wr(8'(REG_CONTROL_TWO), 8'h03);
      for (int i = 0; i < 5; i++) begin
         wr(8'(REG_CONTROL_ONE), cfg[i]);
         wr(8'(REG_BURST), code[i]);
         // external clock needs one full period to lock the phase
         h.wt(cfg[i][C1_DIM_CLK] ? win[i] * STEP : 10);
         hi = 0;
         so = 0;
         repeat (win[i] * STEP) begin
            @(negedge sys_clk);
            hi += int'(wave);
            so += int'(dsync.out);
         end
         ex = 16'(((code[i] == 0) ? brightness_voltage_in : code[i]) * STEP);
         note("high", ex);
         seen(16'(hi));
         note("sync_out", ex);
         seen(16'(so));
      end
      note("overlap", 16'h0000);
      seen(16'(ovl));
      note("lamp_sync_io", 16'h0001);
      seen(16'(lsh inside {8'h33, 8'h66, 8'hCC, 8'h99}));
      $display("test burst done");
      #10;
      results();
   end
endmodule : tb

// ==== common/bdc_pkg.sv ====
// shared constants and carrier types of the backlight dimming control
package bdc_pkg;
   // byte register map reached over the serial port
   localparam int NREG            = 12;
   localparam int USER_BYTES      = 8;
   localparam int REG_CONTROL_ONE = 8;
   localparam int REG_CONTROL_TWO = 9;
   localparam int REG_BCSC        = 10;
   localparam int REG_BURST       = 11;
   // field positions
   localparam int C1_DIM_SRC      = 0;
   localparam int C1_DIM_CLK      = 1;
   localparam int C1_DIM_OUT      = 2;
   localparam int C1_LAMP_CLK     = 3;
   localparam int C2_RANGE0       = 0;
   localparam int C2_RANGE1       = 1;
   localparam int BCSC_SHADOW_DIS = 7;
   // values
   localparam logic [7:0] NV_DEFAULT = 8'h00;
   localparam logic [6:0] BURST_FULL = 7'h7F;
   localparam logic [6:0] BURST_MIN  = 7'h01;
   localparam logic [6:0] PHASE_LAST = 7'h7E;
   localparam logic [4:0] LC_MAX     = 5'h1F;
   localparam logic [6:0] PCT_MIN    = 7'h23;
   localparam int PCT_FULL           = 100;
   localparam int PCT_SPAN           = 65;
   // arbitrary slave address base, low bit from the address pin
   localparam logic [6:0] I2C_ADDR_BASE = 7'h58;
   // timing
   localparam int SYS_CLK_HZ       = 10_000_000;
   localparam int NV_WRITE_TIME_US = 10;
   localparam int NV_WRITE_CYCLES  =
      NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);
   localparam logic [6:0] NV_BUSY  = 7'(NV_WRITE_CYCLES);
   // system clocks per burst step, indexed by the range bits
   localparam logic [3:0][9:0] STEP_CYCLES =
      {10'h032, 10'h064, 10'h0C8, 10'h190};

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } bdc_wr_t;

   typedef struct packed {
      logic ch1_a;
      logic ch1_b;
      logic ch2_a;
      logic ch2_b;
   } bdc_gate_t;

   typedef struct packed {
      logic out;
      logic oe;
   } bdc_pin_t;
endpackage : bdc_pkg

// ==== core/bdc_i2c_slave.sv ====
// byte-register serial slave with auto-incrementing pointer
`timescale 1ns/1ps
module bdc_i2c_slave import bdc_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       addr_pin,
   input  wire logic       busy,
   input  wire logic [7:0] rd_data,
   output logic [7:0]      rd_addr,
   output bdc_wr_t         wr,
   output bdc_pin_t        sda
);
   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08,
      S_WACK = 7'h10, S_RD = 7'h20, S_RACK = 7'h40
   } bdc_i2c_state_t;

   typedef struct packed {
      logic [2:0]     s1;
      logic [2:0]     s2;
      logic           scl_q;
      logic           sda_q;
      bdc_i2c_state_t state;
      logic [3:0]     bits;
      logic [7:0]     sh;
      logic [7:0]     ptr;
      logic           ptr_ok;
      logic           rw;
      bdc_wr_t        wr;
      logic           oe;
   } bdc_i2c_st_t;

   bdc_i2c_st_t st;
   bdc_i2c_st_t next_st;
   logic        scl, sdai, apin, rise, fall;

   assign scl  = st.s2[0];
   assign sdai = st.s2[1];
   assign apin = st.s2[2];
   assign rise = scl & ~st.scl_q;
   assign fall = ~scl & st.scl_q;

   always_comb begin
      next_st       = st;
      next_st.s1    = {addr_pin, sda_in, scl_in};
      next_st.s2    = st.s1;
      next_st.scl_q = scl;
      next_st.sda_q = sdai;
      next_st.wr.en = 1'b0;
      if (!resetn) begin
         next_st       = '0;
         next_st.state = S_IDLE;
      end else if (scl && st.scl_q && st.sda_q && !sdai) begin
         next_st.state = S_ADDR;
         next_st.bits  = 4'h0;
         next_st.oe    = 1'b0;
      end else if (scl && st.scl_q && !st.sda_q && sdai) begin
         next_st.state = S_IDLE;
         next_st.oe    = 1'b0;
      end else begin
         unique case (st.state)
            S_IDLE: ;
            S_ADDR, S_WR: begin
               if (rise) begin
                  next_st.sh   = {st.sh[6:0], sdai};
                  next_st.bits = st.bits + 4'h1;
               end else if (fall && st.bits == 4'h8) begin
                  next_st.bits  = 4'h0;
                  next_st.state = S_IDLE;
                  // a busy store refuses both address and data
                  if (st.state == S_ADDR) begin
                     if (st.sh[7:1] == {I2C_ADDR_BASE[6:1], apin}
                         && !busy) begin
                        next_st.oe     = 1'b1;
                        next_st.rw     = st.sh[0];
                        next_st.ptr_ok = 1'b0;
                        next_st.state  = S_AACK;
                     end
                  end else if (!busy) begin
                     next_st.oe    = 1'b1;
                     next_st.state = S_WACK;
                     if (!st.ptr_ok) begin
                        next_st.ptr    = st.sh;
                        next_st.ptr_ok = 1'b1;
                     end else begin
                        next_st.wr.en   = 1'b1;
                        next_st.wr.addr = st.ptr;
                        next_st.wr.data = st.sh;
                        next_st.ptr     = st.ptr + 8'h01;
                     end
                  end
               end
            end
            S_AACK: if (fall) begin
               next_st.state = st.rw ? S_RD : S_WR;
               next_st.sh    = rd_data;
               next_st.oe    = st.rw & ~rd_data[7];
            end
            S_WACK: if (fall) begin
               next_st.oe    = 1'b0;
               next_st.state = S_WR;
            end
            S_RD: if (fall) begin
               if (st.bits == 4'h7) begin
                  next_st.oe    = 1'b0;
                  next_st.bits  = 4'h0;
                  next_st.ptr   = st.ptr + 8'h01;
                  next_st.state = S_RACK;
               end else begin
                  next_st.sh   = {st.sh[6:0], 1'b0};
                  next_st.oe   = ~st.sh[6];
                  next_st.bits = st.bits + 4'h1;
               end
            end
            S_RACK: begin
               if (rise && sdai) begin
                  next_st.state = S_IDLE;
               end else if (fall) begin
                  next_st.state = S_RD;
                  next_st.sh    = rd_data;
                  next_st.oe    = ~rd_data[7];
               end
            end
            default: next_st.state = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      st <= next_st;
   end

   assign rd_addr = st.ptr;
   assign wr      = st.wr;
   assign sda.out = 1'b0;
   assign sda.oe  = st.oe;

   property p_wr_pulse;
      @(posedge sys_clk) disable iff (!resetn)
      st.wr.en |=> !st.wr.en;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("register write strobe longer than one cycle");

   property p_ack_drive;
      @(posedge sys_clk) disable iff (!resetn)
      (st.state == S_ADDR && fall && st.bits == 4'h8 && !busy
       && st.sh[7:1] == {I2C_ADDR_BASE[6:1], apin}) |=> st.oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("matching address not acknowledged");
endmodule : bdc_i2c_slave

// ==== core/bdc_top.sv ====
// dimming, clock source and shadowed storage control of the backlight
//
// Notes on behaviour
// - shadow disable resets low; writes reach storage.
// - shadow disable set: volatile writes, no delay.
// - reset restores last values written while stored.
// - eight user bytes, read and write, stored.
// - channel two gate pulses lag channel one.
// - burst waveform has 127 linear duty steps.
// - gates run during burst high, off otherwise.
// - clock select picks internal or pin dimming clock.
// - receiver ignores brightness and oscillator inputs.
// - non-zero burst code takes over from brightness.
// - code one minimum, all ones full duty.
// - lamp current code only from register.
// - current code maps 100% down to 35%.
// - lamp sync pin carries the lamp clock divided by four.
`timescale 1ns/1ps
module bdc_top import bdc_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       por_n,
   input  wire logic       lamp_clk,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output bdc_pin_t        sda,
   input  wire logic       i2c_addr_pin,
   input  wire logic       dimming_osc_pin,
   input  wire logic       dimming_sync_in,
   output bdc_pin_t        dimming_sync,
   input  wire logic [6:0] brightness_level,
   output bdc_pin_t        lamp_sync,
   output bdc_gate_t       gate,
   output logic            burst_dimming_wave,
   output logic [4:0]      lamp_current_code,
   output logic [6:0]      lamp_current_pct
);
   typedef struct packed {
      logic [NREG-1:0][7:0] shadow;
      logic [NREG-1:0][7:0] nv;
      logic                 shadow_disable;
      logic [6:0]           busy;
      logic [1:0]           dosc_s;
      logic                 dosc_q;
      logic [1:0]           dsync_s;
      logic [9:0]           step;
      logic [6:0]           phase;
      logic                 wave;
      bdc_pin_t             dsync;
      logic [4:0]           lc;
      logic [6:0]           pct;
   } bdc_st_t;

   typedef struct packed {
      logic [1:0] rst_s;
      logic [1:0] burst_s;
      logic [1:0] sel_s;
      logic [1:0] q;
      bdc_gate_t  gate;
      bdc_pin_t   lamp_sync_io;
   } bdc_lamp_t;

   bdc_st_t   st;
   bdc_st_t   next_st;
   bdc_lamp_t lt;
   bdc_lamp_t next_lt;
   bdc_wr_t   wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] cr1;
   logic [7:0] cr2;
   logic [6:0] code;
   logic [6:0] brightness_voltage_in_duty;
   logic [6:0] duty;
   logic [9:0] step_last;
   logic       step_tick;
   logic       ext_edge;
   logic       wave_int;
   logic       dim_src;
   logic       dim_clk;
   logic       dim_out;
   logic       wr_hit;
   logic [3:0] widx;
   logic [7:0] wval;

   function automatic logic is_reg(input logic [7:0] a);
      return a < 8'(NREG);
   endfunction : is_reg

   function automatic logic [6:0] pct_of(input logic [4:0] c);
      return 7'(PCT_FULL - (PCT_SPAN * int'(c)) / int'(LC_MAX));
   endfunction : pct_of

   bdc_i2c_slave u_slave (
      .sys_clk  (sys_clk),
      .resetn   (resetn & por_n),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .addr_pin (i2c_addr_pin),
      .busy     (st.busy != 7'h00),
      .rd_data  (rd_data),
      .rd_addr  (rd_addr),
      .wr       (wr),
      .sda      (sda)
   );

   assign cr1     = st.shadow[REG_CONTROL_ONE];
   assign cr2     = st.shadow[REG_CONTROL_TWO];
   assign dim_src = cr1[C1_DIM_SRC];
   assign dim_clk = cr1[C1_DIM_CLK];
   assign dim_out = cr1[C1_DIM_OUT];
   assign code    = st.shadow[REG_BURST][6:0];
   assign wr_hit  = wr.en && is_reg(wr.addr) && resetn && por_n;

   always_comb begin
      rd_data = 8'h00;
      if (is_reg(rd_addr)) begin
         rd_data = st.shadow[rd_addr[3:0]];
         if (rd_addr == 8'(REG_BCSC)) begin
            rd_data[BCSC_SHADOW_DIS] = st.shadow_disable;
         end
      end
   end

   assign brightness_voltage_in_duty = (brightness_level == 7'h00) ? BURST_MIN
                                                    : brightness_level;
   assign duty      = (code != 7'h00) ? code : brightness_voltage_in_duty;
   assign wave_int  = st.phase < duty;
   assign step_last = STEP_CYCLES[{cr2[C2_RANGE1], cr2[C2_RANGE0]}]
                      - 10'h001;
   assign step_tick = st.step == step_last;
   assign ext_edge  = st.dosc_s[1] & ~st.dosc_q;

   always_comb begin
      widx = wr.addr[3:0];
      wval = wr.data;
      if (widx == 4'(REG_BCSC)) begin
         wval = {3'b000, wr.data[4:0]};
      end else if (widx == 4'(REG_BURST)) begin
         wval = {1'b0, wr.data[6:0]};
      end
   end

   always_comb begin
      next_st         = st;
      next_st.dosc_s  = {st.dosc_s[0], dimming_osc_pin};
      next_st.dosc_q  = st.dosc_s[1];
      next_st.dsync_s = {st.dsync_s[0], dimming_sync_in};
      next_st.busy    = (st.busy != 7'h00) ? st.busy - 7'h01 : 7'h00;
      next_st.step    = step_tick ? 10'h000 : st.step + 10'h001;
      if (dim_clk) begin
         if (ext_edge) begin
            next_st.phase = 7'h00;
            next_st.step  = 10'h000;
         end else if (step_tick && st.phase != PHASE_LAST) begin
            next_st.phase = st.phase + 7'h01;
         end
      end else if (step_tick) begin
         next_st.phase = (st.phase == PHASE_LAST) ? 7'h00
                                                  : st.phase + 7'h01;
      end
      next_st.wave      = dim_src ? st.dsync_s[1] : wave_int;
      next_st.dsync.out = wave_int;
      next_st.dsync.oe  = !dim_src && !dim_out;
      next_st.lc        = st.shadow[REG_BCSC][4:0];
      next_st.pct       = pct_of(st.shadow[REG_BCSC][4:0]);
      if (wr_hit) begin
         next_st.shadow[widx] = wval;
         if (widx == 4'(REG_BCSC)) begin
            next_st.shadow_disable = wr.data[BCSC_SHADOW_DIS];
         end
         if (!st.shadow_disable) begin
            next_st.nv[widx] = wval;
            next_st.busy     = NV_BUSY;
         end
      end
      if (!por_n) begin
         next_st        = '0;
         next_st.nv     = {NREG{NV_DEFAULT}};
         next_st.shadow = {NREG{NV_DEFAULT}};
      end else if (!resetn) begin
         next_st        = '0;
         next_st.nv     = st.nv;
         next_st.shadow = st.nv;
      end
   end

   always_ff @(posedge sys_clk) begin
      st <= next_st;
   end

   assign dimming_sync       = st.dsync;
   assign burst_dimming_wave = st.wave;
   assign lamp_current_code  = st.lc;
   assign lamp_current_pct   = st.pct;

   // lamp side: four lamp clock ticks make one lamp cycle
   always_comb begin
      next_lt         = lt;
      next_lt.rst_s   = {lt.rst_s[0], resetn & por_n};
      next_lt.burst_s = {lt.burst_s[0], st.wave};
      next_lt.sel_s   = {lt.sel_s[0], cr1[C1_LAMP_CLK]};
      if (!lt.rst_s[1]) begin
         next_lt.q     = 2'b00;
         next_lt.gate  = '0;
         next_lt.lamp_sync_io = '0;
      end else begin
         next_lt.q = lt.q + 2'b01;
         next_lt.lamp_sync_io.out = lt.q[1];
         next_lt.lamp_sync_io.oe  = !lt.sel_s[1];
         next_lt.gate.ch1_a = lt.burst_s[1] && lt.q == 2'b00;
         next_lt.gate.ch2_a = lt.burst_s[1] && lt.q == 2'b01;
         next_lt.gate.ch1_b = lt.burst_s[1] && lt.q == 2'b10;
         next_lt.gate.ch2_b = lt.burst_s[1] && lt.q == 2'b11;
      end
   end

   always_ff @(posedge lamp_clk) begin
      lt <= next_lt;
   end

   assign gate      = lt.gate;
   assign lamp_sync = lt.lamp_sync_io;

   property p_por_low;
      @(posedge sys_clk)
      !por_n |=> (!st.shadow_disable && st.shadow == st.nv);
   endproperty
   a_por_low: assert property (p_por_low)
      else $error("shadow disable not low after power-up");

   property p_wthru;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (wr_hit && !st.shadow_disable)
         |=> (st.nv[$past(widx)] == $past(wval) && st.busy == NV_BUSY);
   endproperty
   a_wthru: assert property (p_wthru)
      else $error("stored write did not reach storage");

   property p_volatile;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (wr_hit && st.shadow_disable && st.busy == 7'h00)
         |=> ($stable(st.nv) && st.busy == 7'h00
              && st.shadow[$past(widx)] == $past(wval));
   endproperty
   a_volatile: assert property (p_volatile)
      else $error("volatile write touched storage or delayed");

   property p_restore;
      @(posedge sys_clk) disable iff (!por_n)
      !resetn |=> (st.shadow == $past(st.nv) && !st.shadow_disable);
   endproperty
   a_restore: assert property (p_restore)
      else $error("reset did not restore stored image");

   property p_user_read;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (rd_addr < 8'(USER_BYTES)) |-> rd_data == st.shadow[rd_addr[3:0]];
   endproperty
   a_user_read: assert property (p_user_read)
      else $error("user byte read mismatch");

   property p_phase_range;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (step_tick && !dim_clk && st.phase == PHASE_LAST)
         |=> st.phase == 7'h00;
   endproperty
   a_phase_range: assert property (p_phase_range)
      else $error("burst period not 127 steps");

   property p_receiver;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      dim_src |=> st.wave == $past(st.dsync_s[1]);
   endproperty
   a_receiver: assert property (p_receiver)
      else $error("receiver waveform not taken from sync pin");

   property p_ext_clk;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (dim_clk && ext_edge) |=> st.phase == 7'h00;
   endproperty
   a_ext_clk: assert property (p_ext_clk)
      else $error("external dimming clock edge ignored");

   property p_src_out;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (!dim_src && !dim_out)
         |=> (dimming_sync.oe && dimming_sync.out == $past(wave_int));
   endproperty
   a_src_out: assert property (p_src_out)
      else $error("source waveform not driven on sync pin");

   property p_serial;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (code != 7'h00) |-> duty == code;
   endproperty
   a_serial: assert property (p_serial)
      else $error("non-zero code did not set duty");

   property p_full;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (code == BURST_FULL && !dim_src) [*2] |-> st.wave;
   endproperty
   a_full: assert property (p_full)
      else $error("full code not at full duty");

   property p_pct;
      @(posedge sys_clk) disable iff (!resetn || !por_n)
      (st.shadow[REG_BCSC][4:0] == LC_MAX) |=> lamp_current_pct == PCT_MIN;
   endproperty
   a_pct: assert property (p_pct)
      else $error("largest current code not 35 percent");

   property p_gate_off;
      @(posedge lamp_clk) disable iff (!lt.rst_s[1])
      !lt.burst_s[1] |=> gate == '0;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("gates driven outside burst");

   property p_phased;
      @(posedge lamp_clk) disable iff (!lt.rst_s[1])
      (gate.ch1_a && lt.burst_s[1]) |=> (gate.ch2_a && !gate.ch1_a);
   endproperty
   a_phased: assert property (p_phased)
      else $error("channel two not offset from channel one");

   property p_lamp_sync_io;
      @(posedge lamp_clk) disable iff (!lt.rst_s[1])
      $rose(lamp_sync.out) |=> lamp_sync.out ##1 !lamp_sync.out;
   endproperty
   a_lamp_sync_io: assert property (p_lamp_sync_io)
      else $error("lamp sync output not a steady clock");

   c_serial: cover property (@(posedge sys_clk)
      wr_hit && widx == 4'(REG_BURST) && wr.data != 8'h00);
   c_receiver: cover property (@(posedge sys_clk)
      dim_src && $rose(st.wave));
   c_ext: cover property (@(posedge sys_clk) dim_clk && ext_edge);
   c_ch2: cover property (@(posedge lamp_clk) gate.ch2_a);
endmodule : bdc_top
